/* File: hw/uar_defs.vh */
// Constants for the asynchronous UART receiver
// Assumes one 100 MHz system clock and a plain register port
`ifndef UAR_DEFS_VH
`define UAR_DEFS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define UAR_ADDR_W 3
`define UAR_OFF_CTRL0 3'h0
`define UAR_OFF_CTRL1 3'h1
`define UAR_OFF_DIV 3'h2
`define UAR_OFF_RXB 3'h3
`define UAR_OFF_STAT 3'h4
`define UAR_OFF_IMASK 3'h5
`define UAR_OFF_ISTAT 3'h6

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UAR_C0_MODE_LO 0
`define UAR_C0_MODE_HI 3
`define UAR_C0_BRGH 4
`define UAR_C0_RECEIVER_ENABLE 5
`define UAR_C0_PAR 6
`define UAR_C1_ON 0
`define UAR_C1_FEIE 1
`define UAR_C1_PEIE 2
`define UAR_ST_RXF 0
`define UAR_ST_FERR 1
`define UAR_ST_PERR 2
`define UAR_ST_EMPTY 3
`define UAR_IS_CHAR 0
`define UAR_IS_FERR 1
`define UAR_IS_OVR 2
`define UAR_IS_GLITCH 3

// ------------------------------------------------------------
// Reset values and timing counts
// ------------------------------------------------------------
`define UAR_RST_CTRL0 8'h00
`define UAR_RST_CTRL1 8'h00
`define UAR_RST_DIV 16'h0000
`define UAR_RST_IMASK 4'h0
`define UAR_MODE_MAX 4'h3
`define UAR_MODE_7BIT 4'h1
`define UAR_MODE_PAR_LO 4'h2
`define UAR_TICKS_HS 4'h3
`define UAR_TICKS_NS 4'hF
`define UAR_HS_MID 4'h1
`define UAR_NS_E1 4'h1
`define UAR_NS_E2 4'h2
`define UAR_NS_S1 4'h7
`define UAR_NS_S2 4'h8
`define UAR_NS_S3 4'h9

`endif

/* File: hw/uar_rx.v */
// Asynchronous UART receiver: bit recovery, two-entry FIFO, flags
// Assumes inputs synchronous to clk except the serial line rx_in
//
// Implementation choices: the placing of the registers and the plain strobed port.
`include "uar_defs.vh"

module uar_rx (
    clk,
    nrst,
    clk_en,
    rx_in,
    addr,
    wdata,
    wr_stb,
    rd_stb,
    rdata,
    receive_flag,
    irq
);
    input wire clk;
    input wire nrst;
    input wire clk_en;
    input wire rx_in;
    input wire [`UAR_ADDR_W-1:0] addr;
    input wire [7:0] wdata;
    input wire wr_stb;
    input wire rd_stb;
    output reg [7:0] rdata;
    output wire receive_flag;
    output wire irq;

    // Receiver states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_EARLY = 3'd1;
    localparam [2:0] ST_START = 3'd2;
    localparam [2:0] ST_DATA = 3'd3;
    localparam [2:0] ST_PAR = 3'd4;
    localparam [2:0] ST_STOP = 3'd5;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Programmed configuration, mask and sticky events
    reg [7:0] control_reg_0_q;
    reg [7:0] control_reg_1_q;
    reg [15:0] baud_divisor_q;
    reg [3:0] imask_q;
    reg [3:0] istat_q;

    // Configuration fields
    wire [3:0] mode = control_reg_0_q[`UAR_C0_MODE_HI:`UAR_C0_MODE_LO];
    wire high_speed = control_reg_0_q[`UAR_C0_BRGH];
    wire receiver_enable = control_reg_0_q[`UAR_C0_RECEIVER_ENABLE];
    wire par_odd = control_reg_0_q[`UAR_C0_PAR];
    wire module_on = control_reg_1_q[`UAR_C1_ON];
    wire framing_error_enable = control_reg_1_q[`UAR_C1_FEIE];
    wire parity_error_enable = control_reg_1_q[`UAR_C1_PEIE];
    wire rx_active = module_on && receiver_enable && (mode <= `UAR_MODE_MAX);
    wire seven_bit = (mode == `UAR_MODE_7BIT);
    wire use_par = (mode >= `UAR_MODE_PAR_LO);

    // ------------------------------------------------------------
    // Line synchroniser and baud tick
    // ------------------------------------------------------------
    // Synchroniser stages, edge history and baud count
    reg rx_meta_q;
    reg rx_sync_q;
    reg rx_prev_q;
    reg [15:0] brg_cnt_q;
    // One tick is one baud-generator clock
    wire tick = (brg_cnt_q == 16'h0000);

    always @(posedge clk) begin
        if (!nrst) begin
            // Idle level, so no false edge follows reset
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (clk_en) begin
            rx_meta_q <= rx_in;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // ------------------------------------------------------------
    // Data recovery
    // ------------------------------------------------------------
    // Recovery state, sample count and the character in progress
    reg [2:0] state_q;
    reg [3:0] sub_q;
    reg [2:0] bit_q;
    reg [1:0] low_q;
    reg [7:0] receive_shift_register_q;
    reg par_q;
    reg perr_q;
    reg push_q;
    reg push_ferr_q;
    reg glitch_q;

    // Sample positions for the current speed
    wire [3:0] last_sub = high_speed ? `UAR_TICKS_HS : `UAR_TICKS_NS;
    wire [2:0] last_bit = seven_bit ? 3'd6 : 3'd7;
    wire is_sample = high_speed ? (sub_q == `UAR_HS_MID) :
        (sub_q == `UAR_NS_S1 || sub_q == `UAR_NS_S2 || sub_q == `UAR_NS_S3);
    wire [1:0] low_n = low_q + {1'b0, ~rx_sync_q};
    wire bit_val = high_speed ? rx_sync_q : (low_n < 2'd2);
    wire decide = tick && (high_speed ? (sub_q == `UAR_HS_MID) : (sub_q == `UAR_NS_S3));

    always @(posedge clk) begin
        if (!nrst) begin
            brg_cnt_q <= 16'h0000;
        end else if (clk_en) begin
            // Held at reload while idle, so ticks are timed from the edge
            if (state_q == ST_IDLE || tick)
                brg_cnt_q <= baud_divisor_q;
            else
                brg_cnt_q <= brg_cnt_q - 16'h0001;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            sub_q <= 4'h0;
            bit_q <= 3'd0;
            low_q <= 2'd0;
            receive_shift_register_q <= 8'h00;
            par_q <= 1'b0;
            perr_q <= 1'b0;
            push_q <= 1'b0;
            push_ferr_q <= 1'b0;
            glitch_q <= 1'b0;
        end else if (clk_en) begin
            push_q <= 1'b0;
            glitch_q <= 1'b0;
            if (!rx_active) begin
                state_q <= ST_IDLE;
            end else if (state_q == ST_IDLE) begin
                if (rx_prev_q && !rx_sync_q) begin
                    state_q <= high_speed ? ST_START : ST_EARLY;
                    sub_q <= 4'h0;
                    low_q <= 2'd0;
                end
            end else if (tick) begin
                sub_q <= (sub_q == last_sub) ? 4'h0 : sub_q + 4'h1;
                if (is_sample && !rx_sync_q)
                    low_q <= low_q + 2'd1;
                case (state_q)
                    ST_EARLY: begin
                        // Low pulses already high again at both early samples (E1, E2) are dropped and raise the glitch event
                        // glitch check
                        if (sub_q == `UAR_NS_E1 && !rx_sync_q)
                            low_q <= 2'd1;
                        if (sub_q == `UAR_NS_E2) begin
                            if (rx_sync_q && low_q == 2'd0) begin
                                state_q <= ST_IDLE;
                                glitch_q <= 1'b1;
                            end else begin
                                state_q <= ST_START;
                            end
                            low_q <= 2'd0;
                        end
                    end
                    ST_START: begin
                        // A start bit voted high is dropped silently
                        // start qualification
                        if (decide) begin
                            low_q <= 2'd0;
                            bit_q <= 3'd0;
                            par_q <= 1'b0;
                            if (bit_val)
                                state_q <= ST_IDLE;
                            else
                                state_q <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (decide) begin
                            low_q <= 2'd0;
                            receive_shift_register_q <=
                                {bit_val, receive_shift_register_q[7:1]};
                            par_q <= par_q ^ bit_val;
                            bit_q <= bit_q + 3'd1;
                            if (bit_q == last_bit)
                                state_q <= use_par ? ST_PAR : ST_STOP;
                        end
                    end
                    ST_PAR: begin
                        if (decide) begin
                            low_q <= 2'd0;
                            perr_q <= (par_q ^ bit_val) != par_odd;
                            state_q <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (decide) begin
                            low_q <= 2'd0;
                            // Seven-bit characters take one more shift into the low bits
                            if (seven_bit)
                                receive_shift_register_q <=
                                    {1'b0, receive_shift_register_q[7:1]};
                            if (!use_par)
                                perr_q <= 1'b0;
                            push_ferr_q <= ~bit_val;
                            push_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Two-entry FIFO
    // ------------------------------------------------------------
    // Each entry keeps its error bits, so the flags follow the head
    reg [9:0] fifo_q [0:1];
    reg rd_ptr_q;
    reg wr_ptr_q;
    reg [1:0] count_q;
    wire rd_rxb = rd_stb && (addr == `UAR_OFF_RXB);
    wire pop = rd_rxb && (count_q != 2'd0);
    wire full = (count_q == 2'd2);
    wire do_push = push_q && !full;
    wire [9:0] head = fifo_q[rd_ptr_q];
    wire framing_error_flag = (count_q != 2'd0) && head[8];
    wire parity_error_flag = (count_q != 2'd0) && head[9];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ent
            always @(posedge clk) begin
                if (!nrst)
                    fifo_q[gi] <= 10'h000;
                else if (clk_en && do_push && wr_ptr_q == gi)
                    fifo_q[gi] <= {perr_q, push_ferr_q, receive_shift_register_q};
            end
        end
    endgenerate

    // Pointers and occupancy; a push into a full FIFO is dropped
    always @(posedge clk) begin
        if (!nrst) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q <= 2'd0;
        end else if (clk_en) begin
            if (do_push)
                wr_ptr_q <= ~wr_ptr_q;
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            count_q <= count_q + {1'b0, do_push} - {1'b0, pop};
        end
    end

    wire suppress = (framing_error_flag && framing_error_enable) ||
        (parity_error_flag && parity_error_enable);
    assign receive_flag = (count_q != 2'd0) && !suppress;

    // ------------------------------------------------------------
    // Register port and interrupt status
    // ------------------------------------------------------------
    // Event pulses: character, framing error, overrun, glitch
    wire [3:0] ev = {glitch_q, push_q && full, push_q && push_ferr_q, do_push};
    wire rd_istat = rd_stb && (addr == `UAR_OFF_ISTAT);
    assign irq = |(istat_q & imask_q);

    // Writes; flag has no write path
    always @(posedge clk) begin
        if (!nrst) begin
            control_reg_0_q <= `UAR_RST_CTRL0;
            control_reg_1_q <= `UAR_RST_CTRL1;
            baud_divisor_q <= `UAR_RST_DIV;
            imask_q <= `UAR_RST_IMASK;
            istat_q <= 4'h0;
        end else if (clk_en) begin
            if (wr_stb) begin
                case (addr)
                    `UAR_OFF_CTRL0: control_reg_0_q <= wdata;
                    `UAR_OFF_CTRL1: control_reg_1_q <= wdata;
                    // Divisor takes eight bits; the high byte stays zero
                    `UAR_OFF_DIV: baud_divisor_q <= {8'h00, wdata};
                    `UAR_OFF_IMASK: imask_q <= wdata[3:0];
                    default: ;
                endcase
            end
            // Set wins over read clear
            istat_q <= (rd_istat ? 4'h0 : istat_q) | ev;
        end
    end

    // read mux, data a cycle later
    always @(posedge clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            rdata <= 8'h00;
            if (rd_stb) begin
                case (addr)
                    `UAR_OFF_CTRL0: rdata <= control_reg_0_q;
                    `UAR_OFF_CTRL1: rdata <= control_reg_1_q;
                    `UAR_OFF_DIV: rdata <= baud_divisor_q[7:0];
                    // The pop itself happens in the pointer block
                    `UAR_OFF_RXB: rdata <= head[7:0];
                    `UAR_OFF_STAT: rdata <= {4'h0, count_q == 2'd0,
                        parity_error_flag, framing_error_flag, receive_flag};
                    `UAR_OFF_IMASK: rdata <= {4'h0, imask_q};
                    `UAR_OFF_ISTAT: rdata <= {4'h0, istat_q};
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

/* File: bench/uar_rx_checker.sv */
// Port checker for the asynchronous receiver
// Assumes binding to uar_rx; sees only its ports
`include "uar_defs.vh"
module uar_rx_checker (
    input wire clk,
    input wire nrst,
    input wire clk_en,
    input wire rx_in,
    input wire [`UAR_ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] rdata,
    input wire receive_flag,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Taken status read and a cycle with no register access
    sequence s_rd_stat;
        clk_en && rd_stb && addr == `UAR_OFF_STAT;
    endsequence
    sequence s_quiet;
        clk_en && !rd_stb && !wr_stb;
    endsequence
    AST_RDATA_ZERO: assert property ($past(clk_en && !rd_stb) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (clk_en && rd_stb && addr == 3'h7 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_FLAG_HOLD: assert property (s_quiet ##0 receive_flag |=> receive_flag)
        else $error("receive flag dropped without access");
    AST_FLAG_FALL: assert property ($fell(receive_flag) |-> $past(rd_stb || wr_stb))
        else $error("receive flag fell without access");
    AST_IRQ_HOLD: assert property (s_quiet ##0 irq |=> irq)
        else $error("interrupt dropped without access");
    AST_STAT_FLAG: assert property (s_rd_stat |=>
        rdata[`UAR_ST_RXF] == $past(receive_flag)
        && (!$past(receive_flag) || !rdata[`UAR_ST_EMPTY]))
        else $error("status disagrees with receive flag");
    AST_RESET_CLEAN: assert property ($rose(nrst) |-> !receive_flag && !irq && rdata == 8'h00)
        else $error("outputs not clear after reset");
    AST_IRQ_MASK: assert property (clk_en && wr_stb && addr == `UAR_OFF_IMASK
        && wdata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt high with zero mask");
endmodule

bind uar_rx uar_rx_checker chk_u (.clk(clk), .nrst(nrst), .clk_en(clk_en), .rx_in(rx_in),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .receive_flag(receive_flag), .irq(irq));

/* File: bench/uar_tx_model.sv */
// Remote serial transmitter model driving the receive line
// Assumes the bench clock; one bit lasts CPB clock cycles
module uar_tx_model #(
    parameter int CPB = 16
) (
    input wire logic clk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle line is high
    initial line = 1'h1;
    // start low, LSB first, stop level
    task automatic send(input logic [8:0] bits, input int nb, input logic stop);
        @(posedge clk);
        line <= 1'h0;
        repeat (CPB) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            line <= bits[i];
            repeat (CPB) @(posedge clk);
        end
        line <= stop;
        repeat (CPB) @(posedge clk);
        line <= 1'h1;
    endtask
    // short low pulse on the idle line
    task automatic pulse_low(input int n);
        @(posedge clk);
        line <= 1'h0;
        repeat (n) @(posedge clk);
        line <= 1'h1;
    endtask
endmodule

/* File: bench/tb_uart_async_receiver.sv */
// Self-checking bench for the asynchronous receiver
// Assumes uar_rx, its bound checker and the line model
`include "uar_defs.vh"
module tb_uart_async_receiver;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [`UAR_ADDR_W-1:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'h0;
    logic rd_stb = 1'h0;
    logic clk_en = 1'h1;
    wire [7:0] rdata;
    wire receive_flag;
    wire irq;
    wire line;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int m;
    logic [31:0] seed = 32'h3F6D9CCB;
    logic [7:0] got;
    logic [7:0] e;
    logic [7:0] expq[$];

    // Clock of 10 ns
    always #5 clk = ~clk;

    uar_rx dut_u (.clk(clk), .nrst(nrst), .clk_en(clk_en), .rx_in(line), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .receive_flag(receive_flag), .irq(irq));
    uar_tx_model tx_u (.clk(clk), .line(line));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] act);
        checks++;
        if (act !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, act);
        end
    endtask

    // Register write and read, one strobe cycle each
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge clk);
        wr_stb <= 1'h0;
        #1;
    endtask
    task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge clk);
        rd_stb <= 1'h0;
        #1;
        got = rdata;
        cmp($sformatf("register %0d", a), exp, got);
    endtask

    // Bounded wait for the receive flag level
    task automatic chk_fl(input logic want);
        for (int i = 0; i < 400 && receive_flag !== want; i++) begin
            @(posedge clk);
            #1;
        end
        cmp("receive_flag", {7'h00, want}, {7'h00, receive_flag});
    endtask
    // Interrupt level
    task automatic chk_irq(input logic want);
        cmp("irq", {7'h00, want}, {7'h00, irq});
    endtask

    // Random frame; the model queue keeps it when keep is set
    task automatic frame(input int nb, input logic stop, input logic keep);
        seed = lfsr(seed);
        e = (nb == 7) ? {1'h0, seed[6:0]} : seed[7:0];
        tx_u.send({^e, e}, nb, stop);
        if (keep)
            expq.push_back(e);
    endtask
    task automatic pop();
        chk_rd(`UAR_OFF_RXB, expq.pop_front());
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        #1;
        chk_fl(1'h0);
        chk_rd(`UAR_OFF_STAT, 8'h08);
        chk_rd(3'h7, 8'h00);
        $display("test reset done");
        wr(`UAR_OFF_CTRL1, 8'h03);
        wr(`UAR_OFF_DIV, 8'h00);
        wr(`UAR_OFF_IMASK, 8'h0F);
        for (m = 0; m < 4; m++) begin
            wr(`UAR_OFF_CTRL0, 8'h20 | 8'(m));
            frame((m == 1) ? 7 : (m > 1) ? 9 : 8, 1'h1, 1'h1);
            chk_fl(1'h1);
            pop();
            chk_fl(1'h0);
        end
        chk_irq(1'h1);
        chk_rd(`UAR_OFF_ISTAT, 8'h01);
        $display("test modes done");
        wr(`UAR_OFF_CTRL0, 8'h20);
        frame(8, 1'h1, 1'h1);
        frame(8, 1'h1, 1'h1);
        frame(8, 1'h1, 1'h0);
        chk_fl(1'h1);
        wr(`UAR_OFF_IMASK, 8'h00);
        chk_irq(1'h0);
        wr(`UAR_OFF_IMASK, 8'h0F);
        chk_rd(`UAR_OFF_ISTAT, 8'h05);
        pop();
        chk_fl(1'h1);
        pop();
        chk_fl(1'h0);
        $display("test overrun done");
        frame(8, 1'h0, 1'h1);
        chk_fl(1'h0);
        chk_rd(`UAR_OFF_STAT, 8'h02);
        pop();
        wr(`UAR_OFF_CTRL1, 8'h01);
        frame(8, 1'h0, 1'h1);
        chk_fl(1'h1);
        chk_rd(`UAR_OFF_STAT, 8'h03);
        pop();
        // Even-parity frame against odd parity, parity suppression on
        wr(`UAR_OFF_CTRL1, 8'h05);
        wr(`UAR_OFF_CTRL0, 8'h62);
        frame(9, 1'h1, 1'h1);
        chk_fl(1'h0);
        chk_rd(`UAR_OFF_STAT, 8'h04);
        pop();
        wr(`UAR_OFF_STAT, 8'hFF);
        chk_fl(1'h0);
        chk_rd(`UAR_OFF_ISTAT, 8'h03);
        $display("test framing done");
        tx_u.pulse_low(1);
        repeat (40) @(posedge clk);
        chk_rd(`UAR_OFF_ISTAT, 8'h08);
        tx_u.pulse_low(5);
        repeat (200) @(posedge clk);
        chk_rd(`UAR_OFF_STAT, 8'h08);
        // Mode above 3h keeps the receiver off
        wr(`UAR_OFF_CTRL0, 8'h24);
        frame(8, 1'h1, 1'h0);
        chk_rd(`UAR_OFF_STAT, 8'h08);
        wr(`UAR_OFF_DIV, 8'h03);
        wr(`UAR_OFF_CTRL0, 8'h30);
        frame(8, 1'h1, 1'h1);
        chk_fl(1'h1);
        // A read while the clock enable is low must neither answer nor pop
        @(posedge clk);
        clk_en <= 1'h0;
        chk_rd(`UAR_OFF_RXB, 8'h00);
        @(posedge clk);
        clk_en <= 1'h1;
        pop();
        $display("test glitch and high speed done");
        conclude();
    end
endmodule
